// *** supervisor_params.svh ***
// Constants of the redundant protection supervisor: register offsets, field
// positions, reset values and timing counts.
// Assumes a single 125 MHz system clock; times are given in milliseconds.
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_HZ              125000000
`define HALT_FILTER_MS      500
`define WDOG_TIMEOUT_MS     1000
`define HALT_RELEASE_MS     10000
`define HALT_FILTER_CYC     (`HALT_FILTER_MS * (`CLK_HZ / 1000))
`define WDOG_TIMEOUT_CYC    (`WDOG_TIMEOUT_MS * (`CLK_HZ / 1000))
`define HALT_RELEASE_CYC    (`HALT_RELEASE_MS * (`CLK_HZ / 1000))

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_STATUS          8'h00
`define OFS_EVENT           8'h04
`define OFS_MASK            8'h08
`define OFS_CONTROL         8'h0c
`define OFS_REPORT          8'h10

// ----------------------------------------------------------------------------
// Event bits (event and mask registers share this layout)
// ----------------------------------------------------------------------------
`define EVT_FALLBACK        0
`define EVT_RESTORED        1
`define EVT_TRIP            2
`define EVT_WIRE            3
`define EVT_W               4

// ----------------------------------------------------------------------------
// Control bits and reset values
// ----------------------------------------------------------------------------
`define CTL_TRIP_RESET      0
`define MASK_RESET          4'h0
`define STANDBY_RESET       1'b1

`endif

// *** supervisor_pkg.sv ***
// Types shared by the redundant protection supervisor files.
// Assumes nothing beyond a SystemVerilog compiler.
package supervisor_pkg;

  // Normal and backup sit one bit apart; emergency backup is the power-on state.
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_BACKUP = 2'h1,
    MODE_EMERG  = 2'h3
  } mode_t;

endpackage

// *** filter_if.sv ***
// Signals between the supervisor and its persistence filter.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface filter_if;
  logic raw;
  logic filtered;
  modport src (output raw, input filtered);
  modport flt (input raw, output filtered);
endinterface

// *** persist_filter.sv ***
// Persistence filter: the output rises only after the input has stood high
// for HOLD_CYC consecutive cycles, and falls with the input.
// Assumes the raw input is synchronous to clk.
`timescale 1ns/100ps
`include "supervisor_params.svh"
module persist_filter #(
  parameter logic [31:0] HOLD_CYC = `HALT_FILTER_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  filter_if.flt     f
);

  logic [31:0] cnt_reg;
  logic        out_reg;

  assign f.filtered = out_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 32'h0;
      out_reg <= 1'b0;
    end else if (!f.raw) begin
      cnt_reg <= 32'h0;
      out_reg <= 1'b0;
    end else if (cnt_reg >= HOLD_CYC - 32'h1) begin
      out_reg <= 1'b1; // RULE2
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end

  AST_FILTER_HOLD: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    $rose(out_reg) |-> $past(f.raw) && ($past(cnt_reg) >= HOLD_CYC - 32'h1))
    else $error("Halt filter passed before the hold time.");

endmodule

// *** redundant_protection_supervisor.sv ***
// Redundant protection supervisor: follows the main controller while its
// watchdog pulses arrive and falls back to local engine protection otherwise.
// Assumes all inputs are synchronous to clk and an APB master on the bus.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`include "supervisor_params.svh"

// Summary of operation
// [RULE1] While watchdog pulses arrive, outputs follow the main controller commands.
// [RULE2] In backup, shutdown inputs, filtered halt and overspeed are evaluated locally.
// [RULE3] Fallback keeps the last protected or standby setting of the controller.
// [RULE4] Standby or bypass setting gives emergency backup; shutdown inputs ignored.
// [RULE5] After power-on without a controller, start in emergency backup.
// [RULE6] Report each shutdown input state and each broken-wire flag.
// [RULE7] Report primary battery lost while running from the secondary battery.
// [RULE8] Report halt input state and both solenoid wire fault flags.
// [RULE9] Controller drives common warning, common shutdown, fuel and halt commands.
// [RULE10] Controller drives the standby setting, also high during protection bypass.
// [RULE11] In fallback, own inputs drive the fuel and halt solenoids.
// [RULE12] Fallback begins after one second without any watchdog pulse.
// [RULE13] Controller sends a watchdog pulse about every 0.2 seconds.
// [RULE14] Fallback halt solenoid trips on shutdown, releases ten seconds after zero speed.
// [RULE15] Fallback common shutdown follows halt input or any shutdown input.
// [RULE16] Every watchdog pulse edge restarts the timeout counter.
module redundant_protection_supervisor #(
  parameter logic [31:0] WDOG_TIMEOUT_CYC = `WDOG_TIMEOUT_CYC,
  parameter logic [31:0] HALT_FILTER_CYC  = `HALT_FILTER_CYC,
  parameter logic [31:0] HALT_RELEASE_CYC = `HALT_RELEASE_CYC,
  parameter int          SD_N             = 5
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  input  wire logic [7:0]      paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output logic                 irq,
  input  wire logic            watchdog_pulse,
  input  wire logic            common_warning_cmd,
  input  wire logic            common_shutdown_cmd,
  input  wire logic            fuel_valve_cmd,
  input  wire logic            halt_valve_cmd,
  input  wire logic            standby_app_setting,
  input  wire logic [SD_N-1:0] shutdown_inputs,
  input  wire logic [SD_N-1:0] wire_break_inputs,
  input  wire logic            emergency_halt_input,
  input  wire logic            halt_coil_open,
  input  wire logic            fuel_coil_open,
  input  wire logic            battery_on_secondary,
  input  wire logic            overspeed_detect,
  input  wire logic            engine_speed_zero,
  output logic [SD_N-1:0]      shutdown_state,
  output logic [SD_N-1:0]      broken_wire_flags,
  output logic                 primary_battery_lost,
  output logic                 emergency_halt_state,
  output logic                 halt_coil_wire_fault,
  output logic                 fuel_coil_wire_fault,
  output logic                 halt_solenoid_out,
  output logic                 fuel_solenoid_out,
  output logic                 common_shutdown_out,
  output logic                 common_warning_out
);

  // --------------------------------------------------------------------------
  // Watchdog supervision
  // --------------------------------------------------------------------------
  supervisor_pkg::mode_t mode_reg;
  supervisor_pkg::mode_t mode_next;
  logic        wd_prev_reg;
  logic [31:0] wd_cnt_reg;
  logic        standby_last_reg;
  logic        wd_edge;
  logic        wd_timeout;
  logic        fallback;
  logic        started_reg;

  assign wd_edge    = watchdog_pulse != wd_prev_reg;
  assign wd_timeout = wd_cnt_reg >= WDOG_TIMEOUT_CYC - 32'h1;
  assign fallback   = mode_reg != supervisor_pkg::MODE_NORMAL;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wd_prev_reg <= 1'b0;
      wd_cnt_reg  <= 32'h0;
      started_reg <= 1'b0;
    end else begin
      wd_prev_reg <= watchdog_pulse;
      started_reg <= 1'b1;
      if (wd_edge || fallback) begin
        wd_cnt_reg <= 32'h0; // RULE16
      end else if (!wd_timeout) begin
        wd_cnt_reg <= wd_cnt_reg + 32'h1;
      end
    end
  end

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      supervisor_pkg::MODE_NORMAL: begin
        if (!wd_edge && wd_timeout) begin // RULE12
          mode_next = standby_last_reg ? supervisor_pkg::MODE_EMERG // RULE4
                                       : supervisor_pkg::MODE_BACKUP; // RULE3
        end
      end
      supervisor_pkg::MODE_BACKUP,
      supervisor_pkg::MODE_EMERG: begin
        if (wd_edge) begin
          mode_next = supervisor_pkg::MODE_NORMAL; // RULE1
        end
      end
      default: mode_next = supervisor_pkg::MODE_EMERG;
    endcase
  end

  // Power-on lands in emergency backup until the controller shows up.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_reg         <= supervisor_pkg::MODE_EMERG; // RULE5
      standby_last_reg <= `STANDBY_RESET;
    end else begin
      mode_reg <= mode_next;
      if (!fallback) begin
        standby_last_reg <= standby_app_setting; // RULE3
      end
    end
  end

  // --------------------------------------------------------------------------
  // Local protection
  // --------------------------------------------------------------------------
  filter_if halt_f ();
  assign halt_f.raw = emergency_halt_input;

  persist_filter #(
    .HOLD_CYC (HALT_FILTER_CYC)
  ) u_halt_filter (
    .clk  (clk),
    .nrst (nrst),
    .f    (halt_f)
  );

  logic [SD_N-1:0] sd_eff;
  logic            cause;
  logic            trip_reg;
  logic            trip_next;
  logic            trip_clear;
  logic [31:0]     rel_cnt_reg;
  logic            released_reg;
  logic            fuel_hold_reg;

  // Shutdown channels count only in plain backup.
  assign sd_eff    = (mode_reg == supervisor_pkg::MODE_BACKUP) ? shutdown_inputs
                                                               : {SD_N{1'b0}}; // RULE4
  assign cause     = fallback && (halt_f.filtered || overspeed_detect || (|sd_eff)); // RULE2
  assign trip_next = fallback && (cause || (trip_reg && !trip_clear));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trip_reg      <= 1'b0;
      fuel_hold_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
      if (!fallback) begin
        fuel_hold_reg <= fuel_valve_cmd;
      end
    end
  end

  // The release timer restarts if the engine turns again before it expires.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rel_cnt_reg  <= 32'h0;
      released_reg <= 1'b0;
    end else if (!trip_reg || !engine_speed_zero) begin
      rel_cnt_reg  <= 32'h0;
      released_reg <= 1'b0;
    end else if (rel_cnt_reg >= HALT_RELEASE_CYC - 32'h1) begin
      released_reg <= 1'b1; // RULE14
    end else begin
      rel_cnt_reg <= rel_cnt_reg + 32'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Output stage
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      halt_solenoid_out   <= 1'b0;
      fuel_solenoid_out   <= 1'b0;
      common_shutdown_out <= 1'b0;
      common_warning_out  <= 1'b0;
    end else if (fallback) begin
      halt_solenoid_out   <= trip_next && !released_reg; // RULE11 RULE14
      fuel_solenoid_out   <= fuel_hold_reg && !trip_next; // RULE11
      common_shutdown_out <= trip_next; // RULE15
      common_warning_out  <= 1'b1;
    end else begin
      halt_solenoid_out   <= halt_valve_cmd; // RULE1
      fuel_solenoid_out   <= fuel_valve_cmd;
      common_shutdown_out <= common_shutdown_cmd;
      common_warning_out  <= common_warning_cmd;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shutdown_state       <= {SD_N{1'b0}};
      broken_wire_flags    <= {SD_N{1'b0}};
      primary_battery_lost <= 1'b0;
      emergency_halt_state <= 1'b0;
      halt_coil_wire_fault <= 1'b0;
      fuel_coil_wire_fault <= 1'b0;
    end else begin
      shutdown_state       <= shutdown_inputs; // RULE6
      broken_wire_flags    <= wire_break_inputs; // RULE6
      primary_battery_lost <= battery_on_secondary; // RULE7
      emergency_halt_state <= emergency_halt_input; // RULE8
      halt_coil_wire_fault <= halt_coil_open; // RULE8
      fuel_coil_wire_fault <= fuel_coil_open; // RULE8
    end
  end

  // --------------------------------------------------------------------------
  // APB slave and interrupt
  // --------------------------------------------------------------------------
  logic [`EVT_W-1:0] event_reg;
  logic [`EVT_W-1:0] mask_reg;
  logic [`EVT_W-1:0] event_set;
  logic [`EVT_W-1:0] event_clr;
  logic              wire_any;
  logic              wire_prev_reg;
  logic              setup;
  logic              wr_go;
  logic [31:0]       rd_mux;
  logic              addr_bad;

  assign setup      = psel && !penable;
  assign wr_go      = psel && penable && pready && pwrite;
  assign wire_any   = (|wire_break_inputs) || halt_coil_open || fuel_coil_open;
  assign trip_clear = wr_go && (paddr == `OFS_CONTROL) && pwdata[`CTL_TRIP_RESET];
  assign event_clr  = (wr_go && (paddr == `OFS_EVENT)) ? pwdata[`EVT_W-1:0]
                                                       : {`EVT_W{1'b0}};

  always_comb begin
    event_set                = {`EVT_W{1'b0}};
    event_set[`EVT_FALLBACK] = !fallback && (mode_next != supervisor_pkg::MODE_NORMAL);
    event_set[`EVT_RESTORED] = fallback && (mode_next == supervisor_pkg::MODE_NORMAL);
    event_set[`EVT_TRIP]     = trip_next && !trip_reg;
    event_set[`EVT_WIRE]     = wire_any && !wire_prev_reg;
  end

  always_comb begin
    rd_mux   = 32'h0;
    addr_bad = 1'b0;
    case (paddr)
      `OFS_STATUS:  rd_mux = {26'h0, fuel_solenoid_out, halt_solenoid_out, trip_reg,
                              standby_last_reg, mode_reg};
      `OFS_EVENT:   rd_mux = {28'h0, event_reg};
      `OFS_MASK:    rd_mux = {28'h0, mask_reg};
      `OFS_CONTROL: rd_mux = 32'h0;
      `OFS_REPORT:  rd_mux = {18'h0, fuel_coil_wire_fault, halt_coil_wire_fault,
                              emergency_halt_state, primary_battery_lost,
                              broken_wire_flags, shutdown_state};
      default:      addr_bad = 1'b1;
    endcase
  end

  // One wait-free access phase: data and error are prepared in the setup cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && addr_bad;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_reg     <= {`EVT_W{1'b0}};
      mask_reg      <= `MASK_RESET;
      wire_prev_reg <= 1'b0;
      irq           <= 1'b0;
    end else begin
      wire_prev_reg <= wire_any;
      event_reg     <= (event_reg & ~event_clr) | event_set;
      irq           <= |(((event_reg & ~event_clr) | event_set) & mask_reg);
      if (wr_go && (paddr == `OFS_MASK)) begin
        mask_reg <= pwdata[`EVT_W-1:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  AST_NORMAL_FOLLOWS: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    !fallback |=> halt_solenoid_out == $past(halt_valve_cmd)
                  && fuel_solenoid_out == $past(fuel_valve_cmd))
    else $error("Outputs did not follow the controller in normal mode.");

  AST_TIMEOUT_FALLBACK: assert property (@(posedge clk) disable iff (!nrst) // RULE12
    (!fallback && !wd_edge && wd_cnt_reg == WDOG_TIMEOUT_CYC - 32'h1) |=> fallback)
    else $error("No fallback after the watchdog timeout.");

  AST_EDGE_RESTART: assert property (@(posedge clk) disable iff (!nrst) // RULE16
    (!fallback && wd_edge) |=> (wd_cnt_reg == 32'h0) && !fallback)
    else $error("Watchdog edge did not restart the timeout.");

  AST_KEEP_SETTING: assert property (@(posedge clk) disable iff (!nrst) // RULE3
    (!fallback && $past(!fallback) ##1 fallback) |->
      (mode_reg == (($past(standby_last_reg)) ? supervisor_pkg::MODE_EMERG
                                              : supervisor_pkg::MODE_BACKUP)))
    else $error("Fallback mode does not match the last setting.");

  AST_EMERG_IGNORES_SD: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    (mode_reg == supervisor_pkg::MODE_EMERG && !trip_reg && !halt_f.filtered
     && !overspeed_detect && mode_next == supervisor_pkg::MODE_EMERG) |=> !trip_reg)
    else $error("Shutdown input tripped in emergency backup.");

  AST_POWER_ON_EMERG: assert property (@(posedge clk) disable iff (!nrst) // RULE5
    !started_reg |-> mode_reg == supervisor_pkg::MODE_EMERG)
    else $error("Power-on mode is not emergency backup.");

  AST_REPORT: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    ##1 (shutdown_state == $past(shutdown_inputs)
         && broken_wire_flags == $past(wire_break_inputs)))
    else $error("Shutdown or wire flags not reported.");

  AST_BATTERY: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    $rose(battery_on_secondary) |=> primary_battery_lost)
    else $error("Battery loss not reported.");

  AST_HALT_REPORT: assert property (@(posedge clk) disable iff (!nrst) // RULE8
    ##1 (emergency_halt_state == $past(emergency_halt_input)
         && halt_coil_wire_fault == $past(halt_coil_open)
         && fuel_coil_wire_fault == $past(fuel_coil_open)))
    else $error("Halt state or coil faults not reported.");

  AST_FALLBACK_SOLENOIDS: assert property (@(posedge clk) disable iff (!nrst) // RULE11
    (fallback && halt_f.filtered && !released_reg) |=> halt_solenoid_out && !fuel_solenoid_out)
    else $error("Local halt did not drive the solenoids.");

  AST_HALT_RELEASE: assert property (@(posedge clk) disable iff (!nrst) // RULE14
    (trip_reg && engine_speed_zero && rel_cnt_reg == HALT_RELEASE_CYC - 32'h1)
      |=> released_reg ##1 (!halt_solenoid_out || !fallback))
    else $error("Halt solenoid not released after zero speed.");

  AST_COMMON_SD: assert property (@(posedge clk) disable iff (!nrst) // RULE15
    (fallback && (halt_f.filtered || (|sd_eff))) |=> common_shutdown_out)
    else $error("Common shutdown missing in fallback.");

endmodule

// *** controller_model.sv ***
// Model of the main engine controller: watchdog pulses and command bits.
// Assumes the bench says when the controller is alive and what it commands.
`timescale 1ns/100ps
module controller_model #(
  parameter int SPACING = 40
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       alive,
  input  wire logic [4:0] cmd_in,
  output logic            watchdog_pulse,
  output logic [4:0]      cmd_out
);
  int cnt;

  // A failed controller stops toggling at once, mid-period, as a crash would.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt            <= 0;
      watchdog_pulse <= 1'b0;
    end else if (alive) begin
      cnt <= (cnt == SPACING - 1) ? 0 : cnt + 1;
      if (cnt == SPACING - 1) watchdog_pulse <= !watchdog_pulse;
    end
  end

  // Bit 4 is the standby setting, high also during protection bypass.
  assign cmd_out = cmd_in;
endmodule

// *** tb_redundant_protection_supervisor.sv ***
// Self-checking bench of the redundant protection supervisor.
// Assumes short timing parameters and the controller model beside it.
`timescale 1ns/100ps
module tb_redundant_protection_supervisor;
  localparam int WD  = 50;
  localparam int FLT = 8;
  localparam int REL = 20;
  logic        clk, nrst, psel, penable, pwrite, alive, perr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic        pready, pslverr, irq, wdp;
  logic [4:0]  cmd, cmd_m, sd_in, bw_in, sd_st, bw_fl;
  logic        halt_in, hco, fco, bat2, ovs, spd0;
  logic        bat_lost, halt_st, hwf, fwf, halt_o, fuel_o, csd_o, cwr_o;
  int          error_cnt = 0, n_tests = 0, seed = 6130, cyc = 0;
  logic [65:0] notes[$];
  logic [65:0] nt;
  logic [31:0] sv;
  event        look;

  redundant_protection_supervisor #(.WDOG_TIMEOUT_CYC(WD), .HALT_FILTER_CYC(FLT),
    .HALT_RELEASE_CYC(REL), .SD_N(5)) u_redundant_protection_supervisor (
    .clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .watchdog_pulse(wdp),
    .common_warning_cmd(cmd_m[0]), .common_shutdown_cmd(cmd_m[1]),
    .fuel_valve_cmd(cmd_m[2]), .halt_valve_cmd(cmd_m[3]),
    .standby_app_setting(cmd_m[4]), .shutdown_inputs(sd_in),
    .wire_break_inputs(bw_in), .emergency_halt_input(halt_in),
    .halt_coil_open(hco), .fuel_coil_open(fco), .battery_on_secondary(bat2),
    .overspeed_detect(ovs), .engine_speed_zero(spd0), .shutdown_state(sd_st),
    .broken_wire_flags(bw_fl), .primary_battery_lost(bat_lost),
    .emergency_halt_state(halt_st), .halt_coil_wire_fault(hwf),
    .fuel_coil_wire_fault(fwf), .halt_solenoid_out(halt_o),
    .fuel_solenoid_out(fuel_o), .common_shutdown_out(csd_o),
    .common_warning_out(cwr_o));

  controller_model #(.SPACING(40)) u_controller_model (.clk(clk), .nrst(nrst),
    .alive(alive), .cmd_in(cmd), .watchdog_pulse(wdp), .cmd_out(cmd_m));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Kinds: 0 interrupt, solenoid and alarm outputs, 1 read data, 2 report pins, 3 slave error.
  task automatic note(input logic [1:0] k, input logic [31:0] m, input logic [31:0] e);
    notes.push_back({k, m, e});
    -> look;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    psel    <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench-wide cycle ceiling ends a wait for the slave.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    note(2'h1, m, e);
  endtask

  // The watcher samples a moment after the edge so that edge updates have landed.
  initial forever begin
    @(look);
    #1;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt[65:64])
        2'h0: sv = {27'h0, irq, halt_o, fuel_o, csd_o, cwr_o};
        2'h1: sv = rd;
        2'h2: sv = {18'h0, fwf, hwf, halt_st, bat_lost, bw_fl, sd_st};
        default: sv = {31'h0, perr};
      endcase
      check(sv & nt[63:32], nt[31:0]);
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, alive, cmd, sd_in, bw_in} = '0;
    {halt_in, hco, fco, bat2, ovs, spd0, rd, perr} = '0;
    nrst = 1'b0;
    tick(4);
    nrst <= 1'b1;
    tick(2);
    rd_chk(8'h00, 32'h7, 32'h7);
    note(2'h0, 32'h1, 32'h1);
    rd_chk(8'h40, 32'hffffffff, 32'h0);
    note(2'h3, 32'h1, 32'h1);
    $display("power-on test done");
    alive <= 1'b1;
    tick(45);
    rd_chk(8'h00, 32'h3, 32'h0);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      cmd <= v[4:0];
      sd_in <= v[9:5];
      bw_in <= v[14:10];
      {halt_in, hco, fco, bat2} <= v[18:15];
      tick(3);
      note(2'h0, 32'hf, {28'h0, v[3:0]});
      note(2'h2, 32'h3fff, {18'h0, v[16], v[17], v[18], v[15], v[14:5]});
      rd_chk(8'h10, 32'h3fff, {18'h0, v[16], v[17], v[18], v[15], v[14:5]});
    end
    {sd_in, halt_in} <= '0;
    cmd <= 5'h04;
    apb(8'h08, 1'b1, 32'h1);
    $display("normal test done");
    @(wdp);
    alive <= 1'b0;
    tick(WD - 2);
    note(2'h0, 32'h1, 32'h0);
    tick(4);
    note(2'h0, 32'h1f, 32'h15);
    rd_chk(8'h00, 32'h3, 32'h1);
    apb(8'h04, 1'b1, 32'h1);
    rd_chk(8'h04, 32'h7, 32'h2);
    tick(2);
    note(2'h0, 32'h10, 32'h0);
    sd_in <= 5'h04;
    tick(3);
    note(2'h0, 32'hf, 32'hb);
    sd_in <= 5'h00;
    spd0 <= 1'b1;
    tick(REL - 4);
    note(2'h0, 32'ha, 32'ha);
    tick(8);
    note(2'h0, 32'ha, 32'h2);
    apb(8'h0c, 1'b1, 32'h1);
    spd0 <= 1'b0;
    tick(2);
    note(2'h0, 32'hf, 32'h5);
    ovs <= 1'b1;
    tick(3);
    note(2'h0, 32'h2, 32'h2);
    ovs <= 1'b0;
    apb(8'h0c, 1'b1, 32'h1);
    halt_in <= 1'b1;
    tick(FLT - 3);
    note(2'h0, 32'h2, 32'h0);
    tick(7);
    note(2'h0, 32'h2, 32'h2);
    halt_in <= 1'b0;
    apb(8'h0c, 1'b1, 32'h1);
    $display("backup test done");
    cmd <= 5'h14;
    alive <= 1'b1;
    tick(45);
    rd_chk(8'h00, 32'h3, 32'h0);
    @(wdp);
    alive <= 1'b0;
    tick(WD + 4);
    rd_chk(8'h00, 32'h3, 32'h3);
    sd_in <= 5'h1f;
    tick(4);
    note(2'h0, 32'h2, 32'h0);
    ovs <= 1'b1;
    tick(3);
    note(2'h0, 32'h2, 32'h2);
    rd_chk(8'h04, 32'h4, 32'h4);
    $display("emergency test done");
    tick(2);
    end_sim();
  end
endmodule
